/* cpu_oag_pkg.sv */
// package: addressing modes, instruction lengths and opcode groups for the operand address generator
// assumes 8-bit opcodes whose upper nibble selects the addressing mode group
package cpu_oag_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// addressing modes
	typedef enum logic [3:0] {
		MODE_INH,
		MODE_IMM,
		MODE_DIR,
		MODE_BTB,
		MODE_EXT,
		MODE_IX,
		MODE_IX1,
		MODE_IX2,
		MODE_REL
	} mode_t;

	// instruction lengths in bytes
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;

	// high byte forced onto page-zero addresses
	localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam logic [15:0] PC_RESET = 16'h0000;

	// opcode groups, selected by the upper nibble
	localparam logic [3:0] GRP_BIT_BRANCH = 4'h0;
	localparam logic [3:0] GRP_BIT_MANIP = 4'h1;
	localparam logic [3:0] GRP_BRANCH = 4'h2;
	localparam logic [3:0] GRP_DIR_RMW = 4'h3;
	localparam logic [3:0] GRP_INH_A = 4'h4;
	localparam logic [3:0] GRP_INH_X = 4'h5;
	localparam logic [3:0] GRP_IX1_RMW = 4'h6;
	localparam logic [3:0] GRP_IX_RMW = 4'h7;
	localparam logic [3:0] GRP_CTRL_0 = 4'h8;
	localparam logic [3:0] GRP_CTRL_1 = 4'h9;
	localparam logic [3:0] GRP_IMM = 4'hA;
	localparam logic [3:0] GRP_DIR = 4'hB;
	localparam logic [3:0] GRP_EXT = 4'hC;
	localparam logic [3:0] GRP_IX2 = 4'hD;
	localparam logic [3:0] GRP_IX1 = 4'hE;
	localparam logic [3:0] GRP_IX = 4'hF;

endpackage

/* decode_if.sv */
// interface: opcode in, addressing mode and instruction length out
// assumes a purely combinational decoder on the far side
`timescale 1ns/1ps
interface decode_if;
	logic [7:0] opcode;
	cpu_oag_pkg::mode_t mode;
	logic [1:0] length;

	modport requester(output opcode, input mode, input length);
	modport decoder(input opcode, output mode, output length);
endinterface

/* mode_decoder.sv */
// module: maps an opcode onto its addressing mode and byte length
// assumes the requester presents the opcode in the cycle it needs the answer
`timescale 1ns/1ps
module mode_decoder (
	decode_if.decoder dec
);

	always_comb begin
		dec.mode = cpu_oag_pkg::MODE_INH;
		dec.length = cpu_oag_pkg::LEN_ONE;
		unique case (dec.opcode[7:4])
			cpu_oag_pkg::GRP_BIT_BRANCH: begin
				dec.mode = cpu_oag_pkg::MODE_BTB;
				dec.length = cpu_oag_pkg::LEN_THREE;
			end
			cpu_oag_pkg::GRP_BIT_MANIP, cpu_oag_pkg::GRP_DIR_RMW, cpu_oag_pkg::GRP_DIR: begin
				dec.mode = cpu_oag_pkg::MODE_DIR;
				dec.length = cpu_oag_pkg::LEN_TWO;
			end
			cpu_oag_pkg::GRP_BRANCH: begin
				dec.mode = cpu_oag_pkg::MODE_REL;
				dec.length = cpu_oag_pkg::LEN_TWO;
			end
			cpu_oag_pkg::GRP_INH_A, cpu_oag_pkg::GRP_INH_X, cpu_oag_pkg::GRP_CTRL_0, cpu_oag_pkg::GRP_CTRL_1: begin
				dec.mode = cpu_oag_pkg::MODE_INH;
				dec.length = cpu_oag_pkg::LEN_ONE;
			end
			cpu_oag_pkg::GRP_IX1_RMW, cpu_oag_pkg::GRP_IX1: begin
				dec.mode = cpu_oag_pkg::MODE_IX1;
				dec.length = cpu_oag_pkg::LEN_TWO;
			end
			cpu_oag_pkg::GRP_IX_RMW, cpu_oag_pkg::GRP_IX: begin
				dec.mode = cpu_oag_pkg::MODE_IX;
				dec.length = cpu_oag_pkg::LEN_ONE;
			end
			cpu_oag_pkg::GRP_IMM: begin
				dec.mode = cpu_oag_pkg::MODE_IMM;
				dec.length = cpu_oag_pkg::LEN_TWO;
			end
			cpu_oag_pkg::GRP_EXT: begin
				dec.mode = cpu_oag_pkg::MODE_EXT;
				dec.length = cpu_oag_pkg::LEN_THREE;
			end
			cpu_oag_pkg::GRP_IX2: begin
				dec.mode = cpu_oag_pkg::MODE_IX2;
				dec.length = cpu_oag_pkg::LEN_THREE;
			end
		endcase
	end

endmodule

/* cpu_operand_address_generator.sv */
// module: fetches an instruction's opcode and operand bytes and forms its effective address or branch target
// assumes memory answers each read with mem_rvalid_i, at the earliest in the cycle after mem_rd_o rises
`timescale 1ns/1ps
module cpu_operand_address_generator (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [15:0] pc_i,
	input wire logic [7:0] index_i,
	input wire logic cond_i,
	output logic busy_o,
	output logic mem_rd_o,
	output logic [15:0] mem_addr_o,
	input wire logic [7:0] mem_data_i,
	input wire logic mem_rvalid_i,
	output logic done_o,
	output cpu_oag_pkg::mode_t mode_o,
	output logic [1:0] length_o,
	output logic [7:0] opcode_o,
	output logic [7:0] operand_o,
	output logic operand_valid_o,
	output logic [15:0] ea_o,
	output logic ea_valid_o,
	output logic branch_taken_o,
	output logic [15:0] next_pc_o
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_OPCODE,
		ST_BYTE1,
		ST_BYTE2
	} state_t;

	// ------------------------------------------------------------
	// opcode decode
	// ------------------------------------------------------------
	decode_if dec_bus ();

	mode_decoder u_decoder (
		.dec(dec_bus.decoder)
	);

	state_t state_ff, nxt_state;
	logic [15:0] pc_ff, nxt_pc;
	logic [7:0] opcode_ff, nxt_opcode;
	logic [7:0] b1_ff, nxt_b1;
	logic done_ff, nxt_done;
	cpu_oag_pkg::mode_t mode_ff, nxt_mode;
	logic [1:0] length_ff, nxt_length;
	logic [7:0] operand_ff, nxt_operand;
	logic operand_valid_ff, nxt_operand_valid;
	logic [15:0] ea_ff, nxt_ea;
	logic ea_valid_ff, nxt_ea_valid;
	logic taken_ff, nxt_taken;
	logic [15:0] next_pc_ff, nxt_next_pc;

	// opcode is decoded straight off the bus in its fetch cycle, so one-byte modes finish at once
	assign dec_bus.opcode = (state_ff == ST_OPCODE) ? mem_data_i : opcode_ff;

	// ------------------------------------------------------------
	// fetch sequencer and address arithmetic
	// ------------------------------------------------------------
	always_comb begin
		logic finish;
		logic [7:0] byte1;
		logic [7:0] byte2;
		logic [15:0] seq_pc;
		logic [15:0] disp;
		logic [8:0] sum9;
		finish = 1'b0;
		byte1 = (state_ff == ST_BYTE1) ? mem_data_i : b1_ff;
		byte2 = mem_data_i;
		seq_pc = pc_ff + cpu_oag_pkg::PC_STEP;
		disp = 16'h0000;
		sum9 = {1'b0, index_i} + {1'b0, byte1};
		nxt_state = state_ff;
		nxt_pc = pc_ff;
		nxt_opcode = opcode_ff;
		nxt_b1 = b1_ff;
		nxt_done = 1'b0;
		nxt_mode = mode_ff;
		nxt_length = length_ff;
		nxt_operand = operand_ff;
		nxt_operand_valid = operand_valid_ff;
		nxt_ea = ea_ff;
		nxt_ea_valid = ea_valid_ff;
		nxt_taken = taken_ff;
		nxt_next_pc = next_pc_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (start_i) begin
					nxt_pc = pc_i;
					nxt_state = ST_OPCODE;
				end
			end
			ST_OPCODE: begin
				if (mem_rvalid_i) begin
					nxt_opcode = mem_data_i;
					nxt_pc = seq_pc;
					if (dec_bus.length == cpu_oag_pkg::LEN_ONE) begin
						finish = 1'b1;
					end else begin
						nxt_state = ST_BYTE1;
					end
				end
			end
			ST_BYTE1: begin
				if (mem_rvalid_i) begin
					nxt_b1 = mem_data_i;
					nxt_pc = seq_pc;
					if (dec_bus.length == cpu_oag_pkg::LEN_TWO) begin
						finish = 1'b1;
					end else begin
						nxt_state = ST_BYTE2;
					end
				end
			end
			ST_BYTE2: begin
				if (mem_rvalid_i) begin
					nxt_pc = seq_pc;
					finish = 1'b1;
				end
			end
		endcase
		if (finish) begin
			nxt_state = ST_IDLE;
			nxt_done = 1'b1;
			nxt_mode = dec_bus.mode;
			nxt_length = dec_bus.length;
			nxt_operand = 8'h00;
			nxt_operand_valid = 1'b0;
			nxt_ea = 16'h0000;
			nxt_ea_valid = 1'b0;
			nxt_taken = 1'b0;
			// seq_pc already points past the last byte fetched
			nxt_next_pc = seq_pc;
			unique case (dec_bus.mode)
				cpu_oag_pkg::MODE_INH: begin
					nxt_ea_valid = 1'b0;
				end
				cpu_oag_pkg::MODE_IMM: begin
					nxt_operand = byte1;
					nxt_operand_valid = 1'b1;
				end
				cpu_oag_pkg::MODE_DIR: begin
					nxt_ea = {cpu_oag_pkg::PAGE_ZERO_HI, byte1};
					nxt_ea_valid = 1'b1;
				end
				cpu_oag_pkg::MODE_BTB: begin
					nxt_ea = {cpu_oag_pkg::PAGE_ZERO_HI, byte1};
					nxt_ea_valid = 1'b1;
					disp = {{8{byte2[7]}}, byte2};
					nxt_taken = cond_i;
					if (cond_i) begin
						nxt_next_pc = seq_pc + disp;
					end
				end
				cpu_oag_pkg::MODE_EXT: begin
					nxt_ea = {byte1, byte2};
					nxt_ea_valid = 1'b1;
				end
				cpu_oag_pkg::MODE_IX: begin
					nxt_ea = {cpu_oag_pkg::PAGE_ZERO_HI, index_i};
					nxt_ea_valid = 1'b1;
				end
				cpu_oag_pkg::MODE_IX1: begin
					// the ninth bit is kept, so the reach ends at 0x1FE, two short of page two
					nxt_ea = {7'h00, sum9};
					nxt_ea_valid = 1'b1;
				end
				cpu_oag_pkg::MODE_IX2: begin
					// wraps at the top of memory, no carry out
					nxt_ea = {byte1, byte2} + {cpu_oag_pkg::PAGE_ZERO_HI, index_i};
					nxt_ea_valid = 1'b1;
				end
				cpu_oag_pkg::MODE_REL: begin
					disp = {{8{byte1[7]}}, byte1};
					nxt_taken = cond_i;
					if (cond_i) begin
						nxt_next_pc = seq_pc + disp;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_ff <= ST_IDLE;
			pc_ff <= cpu_oag_pkg::PC_RESET;
			opcode_ff <= 8'h00;
			b1_ff <= 8'h00;
			done_ff <= 1'b0;
			mode_ff <= cpu_oag_pkg::MODE_INH;
			length_ff <= cpu_oag_pkg::LEN_ONE;
			operand_ff <= 8'h00;
			operand_valid_ff <= 1'b0;
			ea_ff <= 16'h0000;
			ea_valid_ff <= 1'b0;
			taken_ff <= 1'b0;
			next_pc_ff <= cpu_oag_pkg::PC_RESET;
		end else begin
			state_ff <= nxt_state;
			pc_ff <= nxt_pc;
			opcode_ff <= nxt_opcode;
			b1_ff <= nxt_b1;
			done_ff <= nxt_done;
			mode_ff <= nxt_mode;
			length_ff <= nxt_length;
			operand_ff <= nxt_operand;
			operand_valid_ff <= nxt_operand_valid;
			ea_ff <= nxt_ea;
			ea_valid_ff <= nxt_ea_valid;
			taken_ff <= nxt_taken;
			next_pc_ff <= nxt_next_pc;
		end
	end

	assign busy_o = (state_ff != ST_IDLE);
	assign mem_rd_o = (state_ff != ST_IDLE);
	assign mem_addr_o = pc_ff;
	assign done_o = done_ff;
	assign mode_o = mode_ff;
	assign length_o = length_ff;
	assign opcode_o = opcode_ff;
	assign operand_o = operand_ff;
	assign operand_valid_o = operand_valid_ff;
	assign ea_o = ea_ff;
	assign ea_valid_o = ea_valid_ff;
	assign branch_taken_o = taken_ff;
	assign next_pc_o = next_pc_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [15:0] start_pc_ff;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			start_pc_ff <= 16'h0000;
		end else if (start_i && state_ff == ST_IDLE) begin
			start_pc_ff <= pc_i;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_accept;
		start_i && state_ff == ST_IDLE;
	endsequence

	sequence s_first_read;
		mem_rd_o && mem_addr_o == start_pc_ff;
	endsequence

	property p_inh_shape;
		done_o && mode_o == cpu_oag_pkg::MODE_INH |-> length_o == 2'h1 && !ea_valid_o && !operand_valid_o;
	endproperty
	a_inh_shape: assert property (p_inh_shape) else $error("inherent result malformed");

	property p_imm_operand;
		done_o && mode_o == cpu_oag_pkg::MODE_IMM |-> length_o == 2'h2 && !ea_valid_o && operand_valid_o
			&& operand_o == $past(mem_data_i);
	endproperty
	a_imm_operand: assert property (p_imm_operand) else $error("immediate operand wrong");

	property p_dir_page;
		done_o && mode_o == cpu_oag_pkg::MODE_DIR |-> ea_valid_o && length_o == 2'h2
			&& ea_o == {8'h00, $past(mem_data_i)};
	endproperty
	a_dir_page: assert property (p_dir_page) else $error("direct address wrong");

	property p_btb_target;
		done_o && mode_o == cpu_oag_pkg::MODE_BTB |-> length_o == 2'h3 && ea_o == {8'h00, $past(b1_ff)}
			&& next_pc_o == (branch_taken_o ? start_pc_ff + 16'h0003 + {{8{$past(mem_data_i[7])}}, $past(mem_data_i)}
			: start_pc_ff + 16'h0003);
	endproperty
	a_btb_target: assert property (p_btb_target) else $error("bit-test branch result wrong");

	property p_ext_addr;
		done_o && mode_o == cpu_oag_pkg::MODE_EXT |-> length_o == 2'h3 && ea_o == {$past(b1_ff), $past(mem_data_i)};
	endproperty
	a_ext_addr: assert property (p_ext_addr) else $error("extended address wrong");

	property p_ix_addr;
		done_o && mode_o == cpu_oag_pkg::MODE_IX |-> length_o == 2'h1 && ea_o == {8'h00, $past(index_i)};
	endproperty
	a_ix_addr: assert property (p_ix_addr) else $error("indexed address wrong");

	property p_ix1_addr;
		done_o && mode_o == cpu_oag_pkg::MODE_IX1 |-> length_o == 2'h2 && ea_o <= 16'h01FE
			&& ea_o == {8'h00, $past(index_i)} + {8'h00, $past(mem_data_i)};
	endproperty
	a_ix1_addr: assert property (p_ix1_addr) else $error("indexed 8-bit offset address wrong");

	property p_ix2_addr;
		done_o && mode_o == cpu_oag_pkg::MODE_IX2 |-> length_o == 2'h3
			&& ea_o == {$past(b1_ff), $past(mem_data_i)} + {8'h00, $past(index_i)};
	endproperty
	a_ix2_addr: assert property (p_ix2_addr) else $error("indexed 16-bit offset address wrong");

	property p_rel_target;
		done_o && mode_o == cpu_oag_pkg::MODE_REL |-> !ea_valid_o
			&& next_pc_o == (branch_taken_o ? start_pc_ff + 16'h0002 + {{8{$past(mem_data_i[7])}}, $past(mem_data_i)}
			: start_pc_ff + 16'h0002);
	endproperty
	a_rel_target: assert property (p_rel_target) else $error("relative target wrong");

	property p_rel_reach;
		done_o && branch_taken_o |-> (next_pc_o - (start_pc_ff + {14'h0000, length_o})) + 16'h0080 <= 16'h00FF;
	endproperty
	a_rel_reach: assert property (p_rel_reach) else $error("branch reach exceeded");

	property p_fetch_start;
		s_accept |=> s_first_read;
	endproperty
	a_fetch_start: assert property (p_fetch_start) else $error("opcode fetch not at start pc");

	property p_pc_advance;
		done_o && !branch_taken_o |-> next_pc_o == start_pc_ff + {14'h0000, length_o} && !busy_o;
	endproperty
	a_pc_advance: assert property (p_pc_advance) else $error("pc not advanced by length");

endmodule

/* prog_mem_model.sv */
// memory partner: program bytes answered one per rvalid after wait_i idle cycles
// assumes the reader holds rd_i and addr_i until it sees rvalid
`timescale 1ns/1ps
module prog_mem_model (
	input wire logic clk_i,
	input wire logic rd_i,
	input wire logic [15:0] addr_i,
	input wire logic [3:0] wait_i,
	output logic rvalid_o,
	output logic [7:0] data_o
);
	logic [7:0] store [logic [15:0]];
	logic [3:0] cnt = 4'h0;
	int fetches = 0;
	logic [15:0] last_addr = 16'h0000;
	initial begin
		rvalid_o = 1'b0;
		data_o = 8'h00;
	end
	// -----------------------------
	// read answer
	// -----------------------------
	// data flips when not valid so a late sample never matches by chance
	always @(posedge clk_i) begin
		rvalid_o <= 1'b0;
		data_o <= ~data_o;
		if (rd_i && !rvalid_o) begin
			if (cnt == wait_i) begin
				cnt <= 4'h0;
				rvalid_o <= 1'b1;
				data_o <= store[addr_i];
				fetches <= fetches + 1;
				last_addr <= addr_i;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule

/* tb_cpu_operand_address_generator.sv */
// testbench: drives instructions through the address generator against a memory model
// assumes inputs change at the falling edge and results are read at the falling edge of done
`timescale 1ns/1ps
module tb_cpu_operand_address_generator;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic start_i = 1'b0;
	logic [15:0] pc_i = 16'h0000;
	logic [7:0] index_i = 8'h00;
	logic cond_i = 1'b0;
	logic [3:0] mem_wait = 4'h0;
	logic busy_o, mem_rd_o, mem_rvalid_i, done_o, operand_valid_o, ea_valid_o, branch_taken_o;
	logic [15:0] mem_addr_o, ea_o, next_pc_o;
	logic [7:0] mem_data_i, opcode_o, operand_o;
	logic [1:0] length_o;
	cpu_oag_pkg::mode_t mode_o;
	int err_total = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #4 mclk_i = ~mclk_i;
	cpu_operand_address_generator dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(start_i), .pc_i(pc_i),
		.index_i(index_i), .cond_i(cond_i), .busy_o(busy_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
		.mem_data_i(mem_data_i), .mem_rvalid_i(mem_rvalid_i), .done_o(done_o), .mode_o(mode_o),
		.length_o(length_o), .opcode_o(opcode_o), .operand_o(operand_o), .operand_valid_o(operand_valid_o),
		.ea_o(ea_o), .ea_valid_o(ea_valid_o), .branch_taken_o(branch_taken_o), .next_pc_o(next_pc_o));
	prog_mem_model mem (.clk_i(mclk_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o), .wait_i(mem_wait),
		.rvalid_o(mem_rvalid_i), .data_o(mem_data_i));
	// -----------------------------
	// shared tasks
	// -----------------------------
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic res(input logic ov, input logic [7:0] op, input logic eav, input logic [15:0] ea,
		input logic tk);
		chk("operand valid", 16'(ov), 16'(operand_valid_o));
		chk("operand", 16'(op), 16'(operand_o));
		chk("ea valid", 16'(eav), 16'(ea_valid_o));
		chk("ea", ea, ea_o);
		chk("taken", 16'(tk), 16'(branch_taken_o));
	endtask
	// a nonzero wait also offers a second start while busy, which must be ignored
	task automatic run(input logic [15:0] pc, input logic [7:0] b0, input logic [7:0] b1,
		input logic [7:0] b2, input logic [7:0] idx, input logic cnd, input logic [3:0] wt,
		input cpu_oag_pkg::mode_t em, input logic [1:0] el, input logic [15:0] enpc);
		int n;
		int f0;
		mem.store[pc] = b0;
		mem.store[pc + 16'h0001] = b1;
		mem.store[pc + 16'h0002] = b2;
		index_i = idx;
		cond_i = cnd;
		mem_wait = wt;
		f0 = mem.fetches;
		start_i = 1'b1;
		pc_i = pc;
		@(negedge mclk_i);
		start_i = 1'b0;
		chk("busy", 16'h0001, 16'(busy_o));
		if (wt != 4'h0) begin
			start_i = 1'b1;
			pc_i = 16'hFFF0;
			@(negedge mclk_i);
			start_i = 1'b0;
		end
		n = 0;
		while (done_o !== 1'b1 && n < 200) begin
			@(negedge mclk_i);
			n++;
		end
		chk("done", 16'h0001, 16'(done_o));
		chk("mode", 16'(em), 16'(mode_o));
		chk("length", 16'(el), 16'(length_o));
		chk("opcode", 16'(b0), 16'(opcode_o));
		chk("fetches", 16'(el), 16'(mem.fetches - f0));
		chk("last fetch", pc + 16'(el) - 16'h0001, mem.last_addr);
		chk("next pc", enpc, next_pc_o);
	endtask
	// -----------------------------
	// scenarios
	// -----------------------------
	task automatic t_modes();
		run(16'h0200, 8'h4C, 8'h11, 8'h22, 8'h33, 1'b0, 4'h0, cpu_oag_pkg::MODE_INH, 2'h1, 16'h0201);
		res(1'b0, 8'h00, 1'b0, 16'h0000, 1'b0);
		run(16'h0300, 8'hA6, 8'h5A, 8'h22, 8'h33, 1'b0, 4'h0, cpu_oag_pkg::MODE_IMM, 2'h2, 16'h0302);
		res(1'b1, 8'h5A, 1'b0, 16'h0000, 1'b0);
		run(16'h0400, 8'hB6, 8'h80, 8'h22, 8'h33, 1'b0, 4'h2, cpu_oag_pkg::MODE_DIR, 2'h2, 16'h0402);
		res(1'b0, 8'h00, 1'b1, 16'h0080, 1'b0);
		run(16'h0600, 8'hC6, 8'h12, 8'h34, 8'h33, 1'b0, 4'h3, cpu_oag_pkg::MODE_EXT, 2'h3, 16'h0603);
		res(1'b0, 8'h00, 1'b1, 16'h1234, 1'b0);
		$display("test modes done");
	endtask
	task automatic t_indexed();
		run(16'h0700, 8'hF6, 8'h11, 8'h22, 8'hC3, 1'b0, 4'h0, cpu_oag_pkg::MODE_IX, 2'h1, 16'h0701);
		res(1'b0, 8'h00, 1'b1, 16'h00C3, 1'b0);
		run(16'h0800, 8'hE6, 8'hFF, 8'h22, 8'hFF, 1'b0, 4'h1, cpu_oag_pkg::MODE_IX1, 2'h2, 16'h0802);
		res(1'b0, 8'h00, 1'b1, 16'h01FE, 1'b0);
		run(16'h0900, 8'hD6, 8'h12, 8'hF0, 8'h20, 1'b0, 4'h0, cpu_oag_pkg::MODE_IX2, 2'h3, 16'h0903);
		res(1'b0, 8'h00, 1'b1, 16'h1310, 1'b0);
		$display("test indexed done");
	endtask
	task automatic t_branch();
		run(16'h0100, 8'h20, 8'h80, 8'h22, 8'h33, 1'b1, 4'h0, cpu_oag_pkg::MODE_REL, 2'h2, 16'h0082);
		res(1'b0, 8'h00, 1'b0, 16'h0000, 1'b1);
		run(16'h0100, 8'h20, 8'h7F, 8'h22, 8'h33, 1'b1, 4'h1, cpu_oag_pkg::MODE_REL, 2'h2, 16'h0181);
		run(16'h0100, 8'h20, 8'h7F, 8'h22, 8'h33, 1'b0, 4'h0, cpu_oag_pkg::MODE_REL, 2'h2, 16'h0102);
		res(1'b0, 8'h00, 1'b0, 16'h0000, 1'b0);
		run(16'h0500, 8'h00, 8'h40, 8'hFE, 8'h33, 1'b1, 4'h0, cpu_oag_pkg::MODE_BTB, 2'h3, 16'h0501);
		res(1'b0, 8'h00, 1'b1, 16'h0040, 1'b1);
		run(16'h0500, 8'h01, 8'h40, 8'hFE, 8'h33, 1'b0, 4'h2, cpu_oag_pkg::MODE_BTB, 2'h3, 16'h0503);
		$display("test branch done");
	endtask
	task automatic t_groups();
		cpu_oag_pkg::mode_t m;
		logic [1:0] l;
		logic [15:0] p;
		for (int g = 0; g < 16; g++) begin
			case (g)
				0: m = cpu_oag_pkg::MODE_BTB;
				1, 3, 11: m = cpu_oag_pkg::MODE_DIR;
				2: m = cpu_oag_pkg::MODE_REL;
				6, 14: m = cpu_oag_pkg::MODE_IX1;
				7, 15: m = cpu_oag_pkg::MODE_IX;
				10: m = cpu_oag_pkg::MODE_IMM;
				12: m = cpu_oag_pkg::MODE_EXT;
				13: m = cpu_oag_pkg::MODE_IX2;
				default: m = cpu_oag_pkg::MODE_INH;
			endcase
			l = 2'h2;
			if (m == cpu_oag_pkg::MODE_INH || m == cpu_oag_pkg::MODE_IX) begin
				l = 2'h1;
			end
			if (g == 0 || g == 12 || g == 13) begin
				l = 2'h3;
			end
			p = 16'h1000 + 16'(g * 4);
			run(p, {4'(g), 4'h1}, 8'h05, 8'h06, 8'h07, 1'b0, 4'h0, m, l, p + 16'(l));
		end
		$display("test groups done");
	endtask
	initial begin
		repeat (16) @(negedge mclk_i);
		rst_n_i = 1'b1;
		chk("busy after reset", 16'h0000, 16'(busy_o));
		chk("read after reset", 16'h0000, 16'(mem_rd_o));
		chk("done after reset", 16'h0000, 16'(done_o));
		@(negedge mclk_i);
		t_modes();
		t_indexed();
		t_branch();
		t_groups();
		tally_and_finish();
	end
endmodule
